// >>> rtl/ctir_claim_store.sv
// claim tag storage with separate set and clear masks
`timescale 1ns/1ps
module ctir_claim_store #(
  parameter int WIDTH = 2
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_set_mask,
  input  wire logic [WIDTH-1:0] i_clr_mask,
  output logic      [WIDTH-1:0] o_tag
);

  logic [WIDTH-1:0] tag_q;
  logic [WIDTH-1:0] tag_d;

  // set applied after clear, so a set never gets lost
  always_comb begin
    tag_d = (tag_q & ~i_clr_mask) | i_set_mask;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tag_q <= WIDTH'(ctir_pkg::CLAIM_RST);
    end else begin
      tag_q <= tag_d;
    end
  end

  assign o_tag = tag_q;

endmodule

// >>> rtl/ctir_pkg.sv
// constants for the claim tag and integration register group
package ctir_pkg;

  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 32;
  localparam int          CLAIM_BITS     = 2;
  localparam int          PERM_INPUTS    = 4;

  // register byte offsets
  localparam logic [11:0] INTEG_CTRL_OFS = 12'h0f00;
  localparam logic [11:0] CLAIM_SET_OFS  = 12'h0fa0;
  localparam logic [11:0] CLAIM_CLR_OFS  = 12'h0fa4;
  localparam logic [11:0] PERM_STAT_OFS  = 12'h0fb8;

  // field positions and reset values
  localparam int          INTEG_MODE_BIT = 0;
  localparam logic        INTEG_MODE_RST = 1'b0;
  localparam logic [1:0]  CLAIM_RST      = 2'h0;
  localparam logic [31:0] CLAIM_SET_READ = 32'h0000_0003;
  localparam int          PERM_FIELD_W   = 2;
  localparam int          PERM_HID_LSB   = 8;
  localparam int          PERM_HYP_NONINVASIVE_DEBUG_STATE_LSB  = 10;
  localparam int          PERM_USED_BITS = 12;

  // permission field encodings
  localparam logic [1:0]  PERM_ABSENT    = 2'h0;
  localparam logic [1:0]  PERM_DISABLED  = 2'h2;
  localparam logic [1:0]  PERM_ENABLED   = 2'h3;

  typedef enum logic [2:0] {
    SEL_NONE  = 3'b000,
    SEL_INTEG = 3'b001,
    SEL_CSET  = 3'b010,
    SEL_CCLR  = 3'b011,
    SEL_PERM  = 3'b100
  } ctir_sel_t;

endpackage

// >>> rtl/ctir_regs.sv
// claim tag, integration control and debug permission registers
`timescale 1ns/1ps
module ctir_regs #(
  parameter int CLAIM_W = ctir_pkg::CLAIM_BITS
) (
  input  wire logic        I_CLK,
  input  wire logic        I_SYS_RST,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [11:0] I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  input  wire logic        I_INV_DBG_EN,
  input  wire logic        I_NONINV_DBG_EN,
  input  wire logic        I_SEC_INV_DBG_EN,
  input  wire logic        I_SEC_NONINV_DBG_EN,
  output logic             O_INTEG_MODE_ON
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic ctir_pkg::ctir_sel_t decode(input logic [11:0] adr);
    ctir_pkg::ctir_sel_t sel;
    sel = ctir_pkg::SEL_NONE;
    if (adr == ctir_pkg::INTEG_CTRL_OFS) begin
      sel = ctir_pkg::SEL_INTEG;
    end else if (adr == ctir_pkg::CLAIM_SET_OFS) begin
      sel = ctir_pkg::SEL_CSET;
    end else if (adr == ctir_pkg::CLAIM_CLR_OFS) begin
      sel = ctir_pkg::SEL_CCLR;
    end else if (adr == ctir_pkg::PERM_STAT_OFS) begin
      sel = ctir_pkg::SEL_PERM;
    end
    return sel;
  endfunction

  // one enable level per field: disabled or enabled
  function automatic logic [1:0] perm_field(input logic en);
    return en ? ctir_pkg::PERM_ENABLED : ctir_pkg::PERM_DISABLED;
  endfunction

  // permission status image from the synchronised inputs
  function automatic logic [31:0] perm_image(input logic [3:0] en);
    logic [31:0] img;
    img = 32'h0000_0000;
    for (int k = 0; k < ctir_pkg::PERM_INPUTS; k++) begin
      img[k*ctir_pkg::PERM_FIELD_W +: ctir_pkg::PERM_FIELD_W] =
        perm_field(en[k]);
    end
    img[ctir_pkg::PERM_HID_LSB +: ctir_pkg::PERM_FIELD_W] =
      ctir_pkg::PERM_ABSENT;
    img[ctir_pkg::PERM_HYP_NONINVASIVE_DEBUG_STATE_LSB +: ctir_pkg::PERM_FIELD_W] =
      ctir_pkg::PERM_ABSENT;
    return img;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // permission input synchronisers

  logic [3:0] perm_raw;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;

  assign perm_raw = {I_SEC_NONINV_DBG_EN, I_SEC_INV_DBG_EN,
                     I_NONINV_DBG_EN, I_INV_DBG_EN};

  generate
    for (genvar g = 0; g < ctir_pkg::PERM_INPUTS; g++) begin : g_sync
      always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= perm_raw[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  ctir_pkg::ctir_sel_t sel;
  logic                req;
  logic                wr_fire;
  logic                ack_q;
  logic                ack_d;
  logic [31:0]         rdat_q;
  logic [31:0]         rdat_d;
  logic                integ_q;
  logic                integ_d;
  logic [CLAIM_W-1:0]  set_mask;
  logic [CLAIM_W-1:0]  clr_mask;
  logic [CLAIM_W-1:0]  claim_tag;

  assign sel = decode(I_WB_ADR);
  assign req = I_WB_CYC & I_WB_STB;
  // write lands on the edge where the master sees ack; all fields in lane 0
  assign wr_fire = req & I_WB_WE & ack_q & I_WB_SEL[0];

  // ack one cycle after the request, dropped the cycle after
  always_comb begin
    ack_d  = req & ~ack_q;
    rdat_d = rdat_q;
    if (req & ~ack_q) begin
      // unmapped reads answer zero, never an error
      rdat_d = 32'h0000_0000;
      if (!I_WB_WE) begin
        if (sel == ctir_pkg::SEL_INTEG) begin
          rdat_d[ctir_pkg::INTEG_MODE_BIT] = integ_q;
        end else if (sel == ctir_pkg::SEL_CSET) begin
          rdat_d = ctir_pkg::CLAIM_SET_READ;
        end else if (sel == ctir_pkg::SEL_CCLR) begin
          rdat_d[CLAIM_W-1:0] = claim_tag;
        end else if (sel == ctir_pkg::SEL_PERM) begin
          rdat_d = perm_image(sync2_q);
        end
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = rdat_q;

  ////////////////////////////////////////////////////////////////////////////
  // integration control and claim tag

  always_comb begin
    integ_d  = integ_q;
    set_mask = '0;
    clr_mask = '0;
    // permission status and upper bits have no write path at all
    if (wr_fire) begin
      if (sel == ctir_pkg::SEL_INTEG) begin
        integ_d = I_WB_DAT[ctir_pkg::INTEG_MODE_BIT];
      end else if (sel == ctir_pkg::SEL_CSET) begin
        set_mask = I_WB_DAT[CLAIM_W-1:0];
      end else if (sel == ctir_pkg::SEL_CCLR) begin
        clr_mask = I_WB_DAT[CLAIM_W-1:0];
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      integ_q <= ctir_pkg::INTEG_MODE_RST;
    end else begin
      integ_q <= integ_d;
    end
  end

  assign O_INTEG_MODE_ON = integ_q;

  // tag is only readable; nothing else in the block looks at it
  ctir_claim_store #(
    .WIDTH      (CLAIM_W)
  ) ctir_claim_store_i (
    .i_clk      (I_CLK),
    .i_rst      (I_SYS_RST),
    .i_set_mask (set_mask),
    .i_clr_mask (clr_mask),
    .o_tag      (claim_tag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  logic        rd_ack;
  logic        wr_at_ack;
  logic [31:0] perm_now;

  assign rd_ack    = ack_q & req & ~I_WB_WE;
  assign wr_at_ack = ack_q & req & I_WB_WE & I_WB_SEL[0];
  assign perm_now  = perm_image(sync2_q);

  ack_single_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (req & ~ack_q) |=> ack_q ##1 !ack_q)
    else $error("ack not one cycle after request");

  integ_write_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (wr_at_ack && I_WB_ADR == ctir_pkg::INTEG_CTRL_OFS)
    |=> O_INTEG_MODE_ON == $past(I_WB_DAT[0]))
    else $error("integration mode bit not written");

  claim_set_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (wr_at_ack && I_WB_ADR == ctir_pkg::CLAIM_SET_OFS)
    |=> claim_tag == ($past(claim_tag) | $past(I_WB_DAT[1:0])))
    else $error("claim set write wrong");

  set_read_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (rd_ack && I_WB_ADR == ctir_pkg::CLAIM_SET_OFS)
    |-> O_WB_DAT == 32'h0000_0003)
    else $error("claim set read not three");

  claim_clr_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (wr_at_ack && I_WB_ADR == ctir_pkg::CLAIM_CLR_OFS)
    |=> claim_tag == ($past(claim_tag) & ~$past(I_WB_DAT[1:0])))
    else $error("claim clear write wrong");

  clr_read_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (rd_ack && I_WB_ADR == ctir_pkg::CLAIM_CLR_OFS)
    |-> O_WB_DAT == {30'h0000_0000, claim_tag})
    else $error("claim clear read not tag");

  claim_reset_a: assert property (
    @(posedge I_CLK)
    I_SYS_RST |=> claim_tag == 2'h0 && !O_WB_ACK)
    else $error("claim tag not zero after reset");

  integ_stable_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    !(wr_at_ack && I_WB_ADR == ctir_pkg::INTEG_CTRL_OFS)
    |=> $stable(O_INTEG_MODE_ON))
    else $error("integration mode changed without write");

  perm_live_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (rd_ack && I_WB_ADR == ctir_pkg::PERM_STAT_OFS)
    |-> O_WB_DAT[7:0] == $past(perm_now[7:0]))
    else $error("permission fields not live");

  hyp_noninvasive_debug_state_zero_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (rd_ack && I_WB_ADR == ctir_pkg::PERM_STAT_OFS)
    |-> O_WB_DAT[11:10] == 2'h0)
    else $error("hypervisor field not zero");

  perm_reserved_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (rd_ack && I_WB_ADR == ctir_pkg::PERM_STAT_OFS)
    |-> O_WB_DAT[31:12] == 20'h0_0000)
    else $error("reserved permission bits set");

  ro_write_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (wr_at_ack && I_WB_ADR == ctir_pkg::PERM_STAT_OFS)
    |=> $stable(claim_tag) && $stable(O_INTEG_MODE_ON) && !O_WB_ACK)
    else $error("read-only write had an effect");

  lane_off_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (ack_q && req && I_WB_WE && !I_WB_SEL[0])
    |=> $stable(claim_tag) && $stable(O_INTEG_MODE_ON))
    else $error("write without lane 0 had an effect");

  hid_zero_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (rd_ack && I_WB_ADR == ctir_pkg::PERM_STAT_OFS)
    |-> O_WB_DAT[9:8] == 2'h0)
    else $error("hypervisor invasive field not zero");

  unmapped_zero_a: assert property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (rd_ack && sel == ctir_pkg::SEL_NONE)
    |-> O_WB_DAT == 32'h0000_0000)
    else $error("unmapped read not zero");

  cov_set_c: cover property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    wr_at_ack && I_WB_ADR == ctir_pkg::CLAIM_SET_OFS);

  cov_clr_c: cover property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    wr_at_ack && I_WB_ADR == ctir_pkg::CLAIM_CLR_OFS && claim_tag != 2'h0);

  cov_perm_c: cover property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    rd_ack && I_WB_ADR == ctir_pkg::PERM_STAT_OFS);

  cov_integ_c: cover property (
    @(posedge I_CLK) disable iff (I_SYS_RST)
    $rose(O_INTEG_MODE_ON));

endmodule

// >>> verif/claim_tag_integration_regs_tb_top.sv
// testbench for the claim tag and integration register group
`timescale 1ns/1ps
module claim_tag_integration_regs_tb_top;
  localparam logic [11:0] A_IT  = ctir_pkg::INTEG_CTRL_OFS;
  localparam logic [11:0] A_SET = ctir_pkg::CLAIM_SET_OFS;
  localparam logic [11:0] A_CLR = ctir_pkg::CLAIM_CLR_OFS;
  localparam logic [11:0] A_PRM = ctir_pkg::PERM_STAT_OFS;
  logic        clk;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        ack;
  logic        mode_on;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [3:0]  perm;
  logic [31:0] wdat;
  logic [31:0] rdat;
  int          fails;
  int          n_tests;

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    perm = 4'h0;
    fails = 0;
    n_tests = 0;
  end

  always #12.5 clk = ~clk;

  ctir_regs ctir_regs_i (
    .I_CLK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_INV_DBG_EN(perm[0]),
    .I_NONINV_DBG_EN(perm[1]), .I_SEC_INV_DBG_EN(perm[2]),
    .I_SEC_NONINV_DBG_EN(perm[3]), .O_INTEG_MODE_ON(mode_on));

  ctir_dbg_master ctir_dbg_master_i (
    .i_clk(clk), .o_cyc(cyc), .o_stb(stb), .o_we(we), .o_adr(adr),
    .o_sel(sel), .o_dat(wdat), .i_dat(rdat), .i_ack(ack));

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr_lane(input logic [11:0] a, input logic [3:0] be,
                         input logic [31:0] d);
    logic [31:0] r;
    ctir_dbg_master_i.xfer(1'b1, a, be, d, r);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wr_lane(a, 4'hf, d);
  endtask

  // pin settles after the ack edge, so look half a cycle later
  task automatic chk_mode(input logic exp);
    @(negedge clk);
    chk("mode pin", 32'(exp), 32'(mode_on));
  endtask

  task automatic rd(input string what, input logic [11:0] a,
                    input logic [31:0] exp);
    logic [31:0] r;
    ctir_dbg_master_i.xfer(1'b0, a, 4'hf, 32'h0000_0000, r);
    chk(what, exp, r);
  endtask

  // input order follows the status field order, two bits per input
  function automatic logic [31:0] perm_exp(input logic [3:0] v);
    logic [31:0] e;
    e = 32'h0000_0000;
    for (int i = 0; i < 4; i++)
      e[2*i +: 2] = v[i] ? ctir_pkg::PERM_ENABLED : ctir_pkg::PERM_DISABLED;
    return e;
  endfunction

  task automatic do_reset(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  task automatic results;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    do_reset(8);
    rd("integ ctrl", A_IT, 32'h0000_0000);
    chk_mode(1'b0);
    rd("claim set", A_SET, ctir_pkg::CLAIM_SET_READ);
    rd("claim clr", A_CLR, 32'h0000_0000);
    $display("test reset values done");
    wr(A_IT, 32'hffff_ffff);
    chk_mode(1'b1);
    rd("integ ctrl", A_IT, 32'h0000_0001);
    wr(A_SET, 32'h0000_0001);
    rd("claim clr", A_CLR, 32'h0000_0001);
    wr(A_SET, 32'hffff_fffe);
    rd("claim clr", A_CLR, 32'h0000_0003);
    wr(A_CLR, 32'h0000_0001);
    rd("claim clr", A_CLR, 32'h0000_0002);
    rd("claim set", A_SET, ctir_pkg::CLAIM_SET_READ);
    chk_mode(1'b1);
    wr_lane(A_CLR, 4'he, 32'hffff_ffff);
    rd("claim clr", A_CLR, 32'h0000_0002);
    wr(A_CLR, 32'hffff_fffe);
    rd("claim clr", A_CLR, 32'h0000_0000);
    wr(A_IT, 32'h0000_0000);
    chk_mode(1'b0);
    $display("test claim and integration done");
    for (int v = 0; v < 16; v++) begin
      perm <= v[3:0];
      // two sync flops plus margin before the status is read
      repeat (3) @(posedge clk);
      wr(A_PRM, 32'hffff_ffff);
      rd("perm status", A_PRM, perm_exp(v[3:0]));
    end
    $display("test permission status done");
    wr(12'h0ff0, 32'hffff_ffff);
    rd("unmapped", 12'h0ff0, 32'h0000_0000);
    rd("claim clr", A_CLR, 32'h0000_0000);
    wr(A_SET, 32'h0000_0003);
    wr(A_IT, 32'h0000_0001);
    rd("claim clr", A_CLR, 32'h0000_0003);
    do_reset(3);
    rd("claim clr", A_CLR, 32'h0000_0000);
    rd("integ ctrl", A_IT, 32'h0000_0000);
    chk_mode(1'b0);
    $display("test unmapped and mid-run reset done");
    results();
  end

  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    $display("unexpected watchdog: expected done, seen hang");
    results();
  end
endmodule

// >>> verif/ctir_dbg_master.sv
// debugger model: classic wishbone master for the register port
`timescale 1ns/1ps
module ctir_dbg_master (
  input  wire logic        i_clk,
  output logic             o_cyc,
  output logic             o_stb,
  output logic             o_we,
  output logic [11:0]      o_adr,
  output logic [3:0]       o_sel,
  output logic [31:0]      o_dat,
  input  wire logic [31:0] i_dat,
  input  wire logic        i_ack
);
  initial begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we = 1'b0;
    o_adr = 12'h000;
    o_sel = 4'h0;
    o_dat = 32'h0000_0000;
  end

  // one classic cycle; no latency assumed, only the bench watchdog ends a wait
  task automatic xfer(input logic we, input logic [11:0] adr,
                      input logic [3:0] be, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge i_clk);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we <= we;
    o_adr <= adr;
    o_sel <= be;
    o_dat <= wd;
    do begin
      @(posedge i_clk);
    end while (i_ack !== 1'b1);
    rd = i_dat;
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    // released address and data lines flip and the lane select clears, so a stale value never looks valid
    o_adr <= ~adr;
    o_dat <= ~wd;
    o_sel <= 4'h0;
  endtask
endmodule
